// ===== core/rcr_regulator_ctrl_regs.sv
// Regulator channel control register bank with enable, mode and voltage selection
`timescale 1ns/1ps

module rcr_regulator_ctrl_regs
	import rcr_pkg::*;
(
	input  wire logic        I_REF_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic [15:0] I_ADDR,
	input  wire logic [15:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [15:0] O_RDATA,
	input  wire logic        I_HW_CTRL1,
	input  wire logic        I_HW_CTRL2,
	input  wire logic        I_HW_EN1,
	input  wire logic        I_HW_EN2,
	input  wire logic [2:0]  I_SEQ_SLOT,
	input  wire logic        I_SEQ_UP,
	input  wire logic        I_UNDERVOLT,
	output logic             O_REG_ENABLE,
	output logic             O_LOW_POWER,
	output logic             O_SWITCH_MODE,
	output logic             O_DISCHARGE,
	output logic      [4:0]  O_VOLT_CODE,
	output logic      [11:0] O_VOLT_MV,
	output logic             O_UV_IRQ,
	output logic             O_SYS_RESET_REQ,
	output logic             O_UV_SHUTDOWN
);

	logic [4:0]    ch7_sleep_volt_code_q;
	rcr_ctrl_type  ctrl_q;
	rcr_slot_type  norm_q;
	rcr_slot_type  sleep8_q;
	rcr_state_type state_q;
	rcr_state_type state_d;
	logic [15:0]   rd_d;
	logic          uv_prev_q;
	logic          uv_evt;
	logic          hwc_act;
	logic          hw_assigned;
	logic          hw_en;
	logic          slot_hit;
	logic          sleep_slot_valid;
	logic          sleep_slot_hit;
	logic          enable_d;
	logic          low_power_d;
	logic [4:0]    volt_d;
	logic          norm_wr;

	// Code to millivolts, fine range then coarse range
	function automatic logic [11:0] volt_to_mv(input logic [4:0] code);
		logic [11:0] mv;
		mv = 12'h000;
		if (code <= VOLT_FINE_LAST) begin
			mv = MV_BASE_FINE + 12'(12'(code) * MV_STEP_FINE);
		end else begin
			mv = MV_BASE_COARSE + 12'(12'(code - VOLT_COARSE_FIRST) * MV_STEP_COARSE);
		end
		return mv;
	endfunction : volt_to_mv

	assign norm_wr = I_WR && (I_ADDR == REG8_NORM_ADDR);

	// Register writes
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			ch7_sleep_volt_code_q <= CH7_SLEEP_RST[4:0];
		end else if (I_WR && I_ADDR == REG7_SLEEP_ADDR) begin
			ch7_sleep_volt_code_q <= I_WDATA[4:0];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			ctrl_q <= rcr_ctrl_type'(CTRL_RST);
		end else if (I_WR && I_ADDR == REG8_CTRL_ADDR) begin
			ctrl_q <= rcr_ctrl_type'(I_WDATA & CTRL_WMASK);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			norm_q <= rcr_slot_type'(NORM_RST);
		end else if (norm_wr) begin
			norm_q <= rcr_slot_type'(I_WDATA & SLOT_WMASK);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			sleep8_q <= rcr_slot_type'(SLEEP8_RST);
		end else if (I_WR && I_ADDR == REG8_SLEEP_ADDR) begin
			sleep8_q <= rcr_slot_type'(I_WDATA & SLOT_WMASK);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (I_ADDR)
			REG7_SLEEP_ADDR: rd_d = {11'h000, ch7_sleep_volt_code_q};
			REG8_CTRL_ADDR:  rd_d = 16'(ctrl_q) & CTRL_WMASK;
			REG8_NORM_ADDR:  rd_d = 16'(norm_q) & SLOT_WMASK;
			REG8_SLEEP_ADDR: rd_d = 16'(sleep8_q) & SLOT_WMASK;
			default:         rd_d = 16'h0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_RDATA <= 16'h0000;
		end else if (I_RD) begin
			O_RDATA <= rd_d;
		end else begin
			O_RDATA <= 16'h0000;
		end
	end

	// Hardware control engagement
	always_comb begin
		case (ctrl_q.hwc_src)
			HWC_NONE:   hwc_act = 1'b0;
			HWC_IN1:    hwc_act = I_HW_CTRL1;
			HWC_IN2:    hwc_act = I_HW_CTRL2;
			HWC_EITHER: hwc_act = I_HW_CTRL1 || I_HW_CTRL2;
			default:    hwc_act = 1'b0;
		endcase
	end

	// Enable source decode
	assign hw_assigned = (norm_q.slot == SLOT_HWEN1) || (norm_q.slot == SLOT_HWEN2);
	assign hw_en       = (norm_q.slot == SLOT_HWEN1) ? I_HW_EN1 : I_HW_EN2;
	assign slot_hit    = (norm_q.slot >= SLOT_FIRST) && (norm_q.slot <= SLOT_LAST)
		&& I_SEQ_UP && (I_SEQ_SLOT == norm_q.slot);
	assign sleep_slot_valid = (sleep8_q.slot >= SLOT_FIRST) && (sleep8_q.slot <= SLOT_LAST);
	// Sleep slot codes count down from timeslot 5 to timeslot 1
	assign sleep_slot_hit = sleep_slot_valid && !I_SEQ_UP
		&& (I_SEQ_SLOT == 3'(SLEEP_SLOT_SUM - sleep8_q.slot));

	// Undervoltage edge
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			uv_prev_q <= 1'b0;
		end else begin
			uv_prev_q <= I_UNDERVOLT;
		end
	end

	assign uv_evt = I_UNDERVOLT && !uv_prev_q;

	// Enable state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (hw_assigned && hw_en) begin
					state_d = ST_ON;
				end else if (slot_hit) begin
					state_d = ST_ON;
				end
			end
			ST_ON: begin
				if (uv_evt && ctrl_q.uv_action == UV_REG_OFF) begin
					state_d = ST_UV_OFF;
				end else if (norm_q.slot == SLOT_NONE) begin
					state_d = ST_OFF;
				end else if (hw_assigned) begin
					if (!hw_en && (!sleep_slot_valid || sleep_slot_hit)) begin
						state_d = ST_OFF;
					end
				end else if (sleep_slot_hit) begin
					state_d = ST_OFF;
				end
			end
			ST_UV_OFF: begin
				// Stays off until software rewrites the normal-state register
				if (norm_wr) begin
					state_d = ST_OFF;
				end
			end
			default: state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Output selection under normal and hardware control
	always_comb begin
		enable_d    = (state_q == ST_ON) && !(hwc_act && ctrl_q.hwc_mode == HWM_OFF);
		low_power_d = norm_q.op_mode;
		if (hwc_act && ctrl_q.hwc_mode != HWM_OFF && ctrl_q.hwc_mode != HWM_ON_MODE) begin
			low_power_d = 1'b1;
		end else if (hwc_act && ctrl_q.hwc_mode == HWM_ON_MODE) begin
			low_power_d = norm_q.op_mode;
		end
		volt_d = (hwc_act && ctrl_q.hwc_vsel) ? sleep8_q.volt : norm_q.volt;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_REG_ENABLE  <= 1'b0;
			O_LOW_POWER   <= 1'b0;
			O_SWITCH_MODE <= 1'b0;
			O_DISCHARGE   <= 1'b1;
			O_VOLT_CODE   <= 5'h00;
			O_VOLT_MV     <= MV_BASE_FINE;
			O_UV_SHUTDOWN <= 1'b0;
		end else begin
			O_REG_ENABLE  <= enable_d;
			O_LOW_POWER   <= low_power_d;
			O_SWITCH_MODE <= ctrl_q.switch_sel;
			O_DISCHARGE   <= !enable_d && !ctrl_q.out_float;
			O_VOLT_CODE   <= volt_d;
			O_VOLT_MV     <= volt_to_mv(volt_d);
			O_UV_SHUTDOWN <= (state_d == ST_UV_OFF);
		end
	end

	// Undervoltage interrupt and system reset request pulses
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_UV_IRQ        <= 1'b0;
			O_SYS_RESET_REQ <= 1'b0;
		end else begin
			O_UV_IRQ        <= uv_evt;
			O_SYS_RESET_REQ <= uv_evt && (ctrl_q.uv_action == UV_SYS_RESET);
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);

	ctrl_read_a: assert property (
		I_RD && I_ADDR == REG8_CTRL_ADDR |=> O_RDATA == ($past(16'(ctrl_q)) & CTRL_WMASK))
		else $error("control register read data wrong");

	uv_irq_a: assert property (
		$rose(I_UNDERVOLT) |=> O_UV_IRQ ##1 !O_UV_IRQ || $rose(I_UNDERVOLT))
		else $error("undervoltage interrupt missing");

	uv_sys_reset_a: assert property (
		$rose(I_UNDERVOLT) && ctrl_q.uv_action == UV_SYS_RESET |=> O_SYS_RESET_REQ)
		else $error("system reset request missing");

	uv_reg_off_a: assert property (
		$rose(I_UNDERVOLT) && ctrl_q.uv_action == UV_REG_OFF && state_q == ST_ON
		|=> O_UV_SHUTDOWN ##1 !O_REG_ENABLE)
		else $error("regulator not shut down on undervoltage");

	uv_ignore_a: assert property (
		$rose(I_UNDERVOLT) && ctrl_q.uv_action == UV_IGNORE |=> !O_SYS_RESET_REQ && !O_UV_SHUTDOWN)
		else $error("ignored undervoltage had an effect");

	hwc_off_a: assert property (
		hwc_act && ctrl_q.hwc_mode == HWM_OFF |=> !O_REG_ENABLE)
		else $error("regulator on while hardware control forces off");

	hwc_either_a: assert property (
		ctrl_q.hwc_src == HWC_EITHER && (I_HW_CTRL1 || I_HW_CTRL2) && ctrl_q.hwc_vsel
		|=> O_VOLT_CODE == $past(sleep8_q.volt))
		else $error("either hardware input did not engage control");

	hwc_lowpower_a: assert property (
		hwc_act && (ctrl_q.hwc_mode == 2'h0 || ctrl_q.hwc_mode == 2'h2) |=> O_LOW_POWER)
		else $error("low power not forced under hardware control");

	volt_fine_a: assert property (
		O_VOLT_CODE <= VOLT_FINE_LAST |-> O_VOLT_MV == 12'(MV_BASE_FINE + O_VOLT_CODE * 12'h032))
		else $error("fine voltage mapping wrong");

	volt_coarse_a: assert property (
		O_VOLT_CODE == 5'h1f |-> O_VOLT_MV == 12'hdac)
		else $error("top voltage code not 3.50V");

	float_hold_a: assert property (
		ctrl_q.out_float [*2] |-> !O_DISCHARGE)
		else $error("discharge active while float selected");

	slot_enable_a: assert property (
		state_q == ST_OFF && slot_hit && !hw_assigned
		|=> state_q == ST_ON ##1 (O_REG_ENABLE || $past(hwc_act && ctrl_q.hwc_mode == HWM_OFF)))
		else $error("timeslot enable not taken");

	hw_enable_a: assert property (
		state_q == ST_OFF && norm_q.slot == SLOT_HWEN2 && I_HW_EN2 |=> state_q == ST_ON)
		else $error("hardware enable 2 ignored");

	hw_enable1_a: assert property (
		state_q == ST_OFF && norm_q.slot == SLOT_HWEN1 && I_HW_EN1 |=> state_q == ST_ON)
		else $error("hardware enable 1 ignored");

	sleep7_read_a: assert property (
		I_RD && I_ADDR == REG7_SLEEP_ADDR |=> O_RDATA == {11'h000, $past(ch7_sleep_volt_code_q)})
		else $error("channel 7 sleep read data wrong");

	norm_read_a: assert property (
		I_RD && I_ADDR == REG8_NORM_ADDR |=> O_RDATA == ($past(16'(norm_q)) & SLOT_WMASK))
		else $error("normal register read data wrong");

	rdata_idle_a: assert property (
		!I_RD |=> O_RDATA == 16'h0000)
		else $error("read data outside read cycle");

	sys_reset_only_a: assert property (
		!(uv_evt && ctrl_q.uv_action == UV_SYS_RESET) |=> !O_SYS_RESET_REQ)
		else $error("spurious system reset request");

	irq_only_a: assert property (
		!uv_evt |=> !O_UV_IRQ)
		else $error("spurious undervoltage interrupt");

	hwc_none_a: assert property (
		ctrl_q.hwc_src == HWC_NONE |=> O_VOLT_CODE == $past(norm_q.volt))
		else $error("hardware control active while disabled");

	hwc_in1_a: assert property (
		ctrl_q.hwc_src == HWC_IN1 && I_HW_CTRL1 && ctrl_q.hwc_vsel
		|=> O_VOLT_CODE == $past(sleep8_q.volt))
		else $error("hardware input 1 did not engage control");

	hwc_in2_idle_a: assert property (
		ctrl_q.hwc_src == HWC_IN2 && !I_HW_CTRL2 |=> O_VOLT_CODE == $past(norm_q.volt))
		else $error("hardware input 2 engaged while low");

	norm_volt_a: assert property (
		hwc_act && !ctrl_q.hwc_vsel |=> O_VOLT_CODE == $past(norm_q.volt))
		else $error("hardware control voltage not normal code");

	hwc_mode_on_a: assert property (
		hwc_act && ctrl_q.hwc_mode == HWM_ON_MODE |=> O_LOW_POWER == $past(norm_q.op_mode))
		else $error("hardware mode did not follow normal mode bit");

	normal_mode_a: assert property (
		!hwc_act |=> O_LOW_POWER == $past(norm_q.op_mode))
		else $error("normal mode bit not applied");

	discharge_on_a: assert property (
		!ctrl_q.out_float && !enable_d |=> O_DISCHARGE)
		else $error("disabled output not discharged");

	switch_mode_a: assert property (
		ctrl_q.switch_sel |=> O_SWITCH_MODE)
		else $error("switch mode not applied");

	slot_none_off_a: assert property (
		state_q == ST_ON && norm_q.slot == SLOT_NONE |=> state_q != ST_ON)
		else $error("slot 000 did not turn off");

	sleep_slot_off_a: assert property (
		state_q == ST_ON && hw_assigned && !hw_en && sleep_slot_hit && !uv_evt
		|=> state_q == ST_OFF)
		else $error("sleep slot did not turn off");

	uv_latch_a: assert property (
		state_q == ST_UV_OFF && !norm_wr |=> state_q == ST_UV_OFF)
		else $error("undervoltage shutdown not held");

endmodule : rcr_regulator_ctrl_regs

// ===== core/rcr_pkg.sv
// Package with register map, field layouts and encodings of the regulator control bank
package rcr_pkg;

	// Register word addresses
	localparam logic [15:0] REG7_SLEEP_ADDR = 16'h407c;
	localparam logic [15:0] REG8_CTRL_ADDR  = 16'h407d;
	localparam logic [15:0] REG8_NORM_ADDR  = 16'h407e;
	localparam logic [15:0] REG8_SLEEP_ADDR = 16'h407f;

	// Writable bits of each register; the rest read as zero
	localparam logic [15:0] CH7_SLEEP_WMASK = 16'h001f;
	localparam logic [15:0] CTRL_WMASK      = 16'hdfc0;
	localparam logic [15:0] SLOT_WMASK      = 16'he11f;

	// Reset values
	localparam logic [15:0] CH7_SLEEP_RST   = 16'h0000;
	localparam logic [15:0] CTRL_RST        = 16'h0200;
	localparam logic [15:0] NORM_RST        = 16'h0000;
	localparam logic [15:0] SLEEP8_RST      = 16'h0100;

	// Channel control word
	typedef struct packed {
		logic [1:0] uv_action;
		logic       rsvd13;
		logic [1:0] hwc_src;
		logic       hwc_vsel;
		logic [1:0] hwc_mode;
		logic       out_float;
		logic       switch_sel;
		logic [5:0] rsvd5_0;
	} rcr_ctrl_type;

	// Normal-state and sleep-state words share one layout
	typedef struct packed {
		logic [2:0] slot;
		logic [3:0] rsvd12_9;
		logic       op_mode;
		logic [2:0] rsvd7_5;
		logic [4:0] volt;
	} rcr_slot_type;

	// Undervoltage error action
	localparam logic [1:0] UV_IGNORE    = 2'h0;
	localparam logic [1:0] UV_REG_OFF   = 2'h1;
	localparam logic [1:0] UV_SYS_RESET = 2'h2;

	// Hardware-control source
	localparam logic [1:0] HWC_NONE     = 2'h0;
	localparam logic [1:0] HWC_IN1      = 2'h1;
	localparam logic [1:0] HWC_IN2      = 2'h2;
	localparam logic [1:0] HWC_EITHER   = 2'h3;

	// Hardware-control operating mode
	localparam logic [1:0] HWM_OFF      = 2'h1;
	localparam logic [1:0] HWM_ON_MODE  = 2'h3;

	// Slot codes
	localparam logic [2:0] SLOT_NONE    = 3'h0;
	localparam logic [2:0] SLOT_FIRST   = 3'h1;
	localparam logic [2:0] SLOT_LAST    = 3'h5;
	localparam logic [2:0] SLOT_HWEN1   = 3'h6;
	localparam logic [2:0] SLOT_HWEN2   = 3'h7;
	// Sleep slot code c leaves in timeslot SLEEP_SLOT_SUM - c
	localparam logic [2:0] SLEEP_SLOT_SUM = 3'h6;

	// Voltage encoding in millivolts
	localparam logic [4:0]  VOLT_FINE_LAST    = 5'h0c;
	localparam logic [4:0]  VOLT_COARSE_FIRST = 5'h0d;
	localparam logic [11:0] MV_BASE_FINE      = 12'h3e8;
	localparam logic [11:0] MV_STEP_FINE      = 12'h032;
	localparam logic [11:0] MV_BASE_COARSE    = 12'h6a4;
	localparam logic [11:0] MV_STEP_COARSE    = 12'h064;

	// Enable state, Gray coded along off -> on -> undervoltage off
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_ON     = 2'b01,
		ST_UV_OFF = 2'b11
	} rcr_state_type;

endpackage : rcr_pkg

// ===== bench/tb_regulator_ctrl_regs.sv
// Self-checking testbench of the regulator control register bank
`timescale 1ns/1ps

module tb_regulator_ctrl_regs
	import rcr_pkg::*;
;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rexp;
	} rcr_row_type;

	logic        i_clk;
	logic        i_rst;
	logic [15:0] i_addr;
	logic [15:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [15:0] o_rdata;
	logic        i_hc1;
	logic        i_hc2;
	logic        i_he1;
	logic        i_he2;
	logic [2:0]  i_slot;
	logic        i_up;
	logic        i_uv;
	logic        o_en;
	logic        o_lp;
	logic        o_sw;
	logic        o_dis;
	logic [4:0]  o_code;
	logic [11:0] o_mv;
	logic        o_irq;
	logic        o_sysrst;
	logic        o_uvoff;
	int          num_errors = 0;
	int          n_compared = 0;

	rcr_row_type rows [9] = '{
		'{16'h407c, 16'hffff, 16'h001f}, '{16'h407d, 16'hffff, 16'hdfc0},
		'{16'h407e, 16'hffff, 16'he11f}, '{16'h407f, 16'hffff, 16'he11f},
		'{16'h4080, 16'hffff, 16'h0000}, '{16'h407b, 16'hffff, 16'h0000},
		'{16'h407c, 16'h0000, 16'h0000}, '{16'h407d, 16'h0000, 16'h0000},
		'{16'h407e, 16'h0000, 16'h0000}
	};

	rcr_regulator_ctrl_regs i_dut (
		.I_REF_CLK(i_clk), .I_SYS_RST(i_rst), .I_ADDR(i_addr), .I_WDATA(i_wdata),
		.I_WR(i_wr), .I_RD(i_rd), .O_RDATA(o_rdata), .I_HW_CTRL1(i_hc1),
		.I_HW_CTRL2(i_hc2), .I_HW_EN1(i_he1), .I_HW_EN2(i_he2), .I_SEQ_SLOT(i_slot),
		.I_SEQ_UP(i_up), .I_UNDERVOLT(i_uv), .O_REG_ENABLE(o_en), .O_LOW_POWER(o_lp),
		.O_SWITCH_MODE(o_sw), .O_DISCHARGE(o_dis), .O_VOLT_CODE(o_code),
		.O_VOLT_MV(o_mv), .O_UV_IRQ(o_irq), .O_SYS_RESET_REQ(o_sysrst),
		.O_UV_SHUTDOWN(o_uvoff)
	);

	always #20 i_clk = ~i_clk;

	task automatic give_verdict;
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : settle

	// Bounded wait for the enable level; running out ends the run
	task automatic wait_en(input logic exp);
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clk);
			#1;
			if (o_en === exp) begin
				chk(16'(o_en), 16'(exp));
				return;
			end
		end
		chk(16'(o_en), 16'(exp));
		give_verdict();
	endtask : wait_en

	// One undervoltage event; counts the one-cycle pulses that follow it
	task automatic uv_event(input int exp_sys);
		int irqs;
		int sys;
		irqs = 0;
		sys = 0;
		@(posedge i_clk);
		i_uv <= 1'b1;
		repeat (6) begin
			@(posedge i_clk);
			#1;
			irqs += (o_irq === 1'b1);
			sys += (o_sysrst === 1'b1);
		end
		i_uv <= 1'b0;
		chk(16'(irqs), 16'h0001);
		chk(16'(sys), 16'(exp_sys));
		settle(1);
	endtask : uv_event

	initial begin
		i_clk = 0; i_rst = 1; i_addr = 0; i_wdata = 0; i_wr = 0; i_rd = 0;
		i_hc1 = 0; i_hc2 = 0; i_he1 = 0; i_he2 = 0; i_slot = 0; i_up = 0; i_uv = 0;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rexp);
		end
		for (int c = 0; c < 32; c++) begin
			wr(REG8_NORM_ADDR, 16'(c));
			settle(2);
			chk(16'(o_code), 16'(c));
			chk(16'(o_mv), c <= 12 ? 16'h03e8 + 16'(c) * 16'h0032
				: 16'h06a4 + 16'(c - 13) * 16'h0064);
		end
		// Hardware-enabled channel, then hardware control on top of it
		wr(REG8_SLEEP_ADDR, 16'h0015);
		wr(REG8_NORM_ADDR, 16'hc00a);
		i_he1 <= 1'b1;
		wait_en(1'b1);
		wr(REG8_CTRL_ADDR, 16'h0e00);
		i_hc2 <= 1'b1;
		settle(3);
		chk(16'(o_code), 16'h000a);
		i_hc1 <= 1'b1;
		settle(3);
		chk(16'(o_code), 16'h0015);
		chk(16'(o_lp), 16'h0001);
		i_hc1 <= 1'b0;
		wr(REG8_CTRL_ADDR, 16'h1c00);
		settle(3);
		chk(16'(o_code), 16'h0015);
		chk(16'(o_lp), 16'h0001);
		wr(REG8_CTRL_ADDR, 16'h1f00);
		settle(3);
		chk(16'(o_lp), 16'h0000);
		wr(REG8_NORM_ADDR, 16'hc10a);
		settle(3);
		chk(16'(o_lp), 16'h0001);
		wr(REG8_CTRL_ADDR, 16'h1d00);
		wait_en(1'b0);
		chk(16'(o_dis), 16'h0001);
		wr(REG8_CTRL_ADDR, 16'h1d80);
		settle(3);
		chk(16'(o_dis), 16'h0000);
		i_hc2 <= 1'b0;
		wait_en(1'b1);
		wr(REG8_CTRL_ADDR, 16'h0040);
		settle(3);
		chk(16'(o_sw), 16'h0001);
		// Down sequence: sleep slot 001 leaves in timeslot 5
		wr(REG8_SLEEP_ADDR, 16'h2000);
		i_he1 <= 1'b0;
		i_slot <= 3'h1;
		settle(4);
		chk(16'(o_en), 16'h0001);
		i_slot <= 3'h5;
		wait_en(1'b0);
		wr(REG8_SLEEP_ADDR, 16'h0000);
		wr(REG8_NORM_ADDR, 16'h6000);
		i_up <= 1'b1;
		i_slot <= 3'h2;
		settle(4);
		chk(16'(o_en), 16'h0000);
		i_slot <= 3'h3;
		wait_en(1'b1);
		wr(REG8_NORM_ADDR, 16'h0000);
		wait_en(1'b0);
		wr(REG8_NORM_ADDR, 16'he000);
		i_he2 <= 1'b1;
		wait_en(1'b1);
		i_he2 <= 1'b0;
		wait_en(1'b0);
		// Undervoltage actions
		wr(REG8_NORM_ADDR, 16'hc000);
		i_he1 <= 1'b1;
		wait_en(1'b1);
		wr(REG8_CTRL_ADDR, 16'h0000);
		uv_event(0);
		chk(16'({o_en, o_uvoff}), 16'h0002);
		wr(REG8_CTRL_ADDR, 16'h4000);
		uv_event(0);
		wait_en(1'b0);
		chk(16'(o_uvoff), 16'h0001);
		wr(REG8_NORM_ADDR, 16'hc000);
		wait_en(1'b1);
		wr(REG8_CTRL_ADDR, 16'h8000);
		uv_event(1);
		wr(REG8_CTRL_ADDR, 16'hc000);
		uv_event(0);
		// Reset in mid-run brings back every default
		i_he1 <= 1'b0;
		i_rst <= 1'b1;
		settle(2);
		i_rst <= 1'b0;
		settle(2);
		chk(16'({o_en, o_lp, o_sw, o_dis}), 16'h0001);
		chk(16'(o_mv), 16'h03e8);
		rd(REG7_SLEEP_ADDR, CH7_SLEEP_RST);
		rd(REG8_CTRL_ADDR, 16'h0200);
		rd(REG8_NORM_ADDR, 16'h0000);
		rd(REG8_SLEEP_ADDR, SLEEP8_RST);
		give_verdict();
	end

endmodule : tb_regulator_ctrl_regs
